// [logic/anpr_cfg.svh]
// Offsets, field positions, reset values and write masks of the negotiation page registers.
`ifndef ANPR_CFG_SVH
`define ANPR_CFG_SVH

`define ANPR_ADDR_W 5
`define ANPR_DATA_W 16

`define ANPR_OFF_MODE_CTRL 5'h00
`define ANPR_OFF_ADV 5'h04
`define ANPR_OFF_LP_BASE 5'h05
`define ANPR_OFF_EXPANSION 5'h06
`define ANPR_OFF_NP_TX 5'h07
`define ANPR_OFF_LP_NP_RX 5'h08

`define ANPR_BIT_RESTART 9
`define ANPR_BIT_NEXT_PAGE 15
`define ANPR_BIT_ACK 14
`define ANPR_BIT_REMOTE_FAULT 13
`define ANPR_BIT_TOGGLE 11
`define ANPR_BIT_ASYM_PAUSE 11

`define ANPR_BIT_EXP_PD_FAULT 4
`define ANPR_BIT_EXP_LP_NP_ABLE 3
`define ANPR_BIT_EXP_LOCAL_NP_ABLE 2
`define ANPR_BIT_EXP_PAGE_RX 1
`define ANPR_BIT_EXP_LP_AN_ABLE 0

`define ANPR_RST_ADV 16'h0DE1
`define ANPR_RST_NP_TX 16'h2001
`define ANPR_RST_ZERO 16'h0000

`define ANPR_WMASK_ADV 16'hBFFF
`define ANPR_WMASK_NP_TX 16'hB7FF

`endif

// [logic/anpr_pkg.sv]
// Types shared by the negotiation page register bank and its neighbours.
package anpr_pkg;

    // One management access as the serial port logic presents it.
    typedef struct packed {
        logic rd;
        logic wr;
        logic [4:0] addr;
        logic [15:0] wdata;
    } anpr_mgmt_req_t;

    // Events and levels from the negotiation engine.
    typedef struct packed {
        logic ability_detect_enter;
        logic page_rx;
        logic rx_is_base;
        logic [15:0] rx_word;
        logic pd_fault;
        logic neg_success;
        logic tx_exchanged;
    } anpr_eng_in_t;

    // Words handed to the negotiation engine.
    typedef struct packed {
        logic [15:0] adv_sampled;
        logic [15:0] np_tx_word;
        logic lp_ack;
        logic restart;
    } anpr_eng_out_t;

    // Whole state of the register bank.
    typedef struct packed {
        logic [15:0] adv;
        logic [15:0] adv_lat;
        logic [15:0] lp_base;
        logic [15:0] np_tx;
        logic [15:0] lp_np;
        logic exp_pd_fault;
        logic exp_page_rx;
        logic exp_lp_np_able;
        logic exp_lp_an_able;
        logic [15:0] rdata;
        logic rd_hit;
        logic restart;
    } anpr_state_t;

endpackage : anpr_pkg

// [logic/anpr_page_regs.sv]
// Negotiation page register bank: advertisement, partner pages, expansion flags and next-page transmit word.
`timescale 1ns/1ps
`include "anpr_cfg.svh"

// How it works
// RULE1: Advertisement bit 15 is writable, resets 0, and requests extra pages.
// RULE2: Advertisement bit 13 goes to partner and clears after successful negotiation.
// RULE3: Pause bits 11 and 10 reset to 1 and only travel to partner; the code also seeds the next-page toggle with the inverse of bit 11.
// RULE4: Advertisement bits 9 to 5 choose advertised abilities, defaults 0,1,1,1,1.
// RULE5: Chip reset restores every advertisement ability bit to its default.
// RULE6: Selector bits 4 to 0 are writable, reset to 00001; software leaves them.
// RULE7: Partner base page register captures the received base page; resets to zero.
// RULE8: Partner bit 15 shows partner extra-page request; valid after completion or page.
// RULE9: Partner bit 14 is the partner acknowledge used to sequence exchange.
// RULE10: Partner bit 13 reports partner remote fault; nothing else acts on it.
// RULE11: Expansion bit 4 latches a parallel detection fault until the register is read.
// RULE12: Expansion bit 3 shows partner extra-page ability; valid after completion or page.
// RULE13: Expansion bit 2 is fixed at 1 and ignores writes.
// RULE14: Expansion bit 1 latches each accepted partner page until the register is read.
// RULE15: Expansion bit 0 shows partner negotiation ability; bits 15 to 5 read zero.
// RULE16: Next-page transmit bit 15 marks more pages follow; resets 0.
// RULE17: Next-page transmit bit 13 marks message page; resets 1.
// RULE18: Next-page bit 12 carries comply flag untouched; bit 14 reads zero.
// RULE19: Toggle bit 11 is read-only and flips against the last exchanged word.
// RULE20: Next-page code bits 10 to 0 reset to null message, sent untouched.
// RULE21: Partner next-page register holds the latest partner extra page.
// RULE22: Advertisement is sampled at ability detection entry; later writes need restart.
// RULE23: Writing restart bit restarts negotiation at once; it self-clears, reads zero.
// RULE24: Read-clear flags clear at read completion; a same-cycle event stays latched.
module anpr_page_regs (
    input wire logic clk,
    input wire logic rst,
    input wire anpr_pkg::anpr_mgmt_req_t mgmt_req,
    output logic [15:0] mgmt_rdata,
    output logic mgmt_rd_hit,
    input wire anpr_pkg::anpr_eng_in_t eng_in,
    input wire logic an_complete,
    output anpr_pkg::anpr_eng_out_t eng_out
);

    // Reset image of the whole bank.
    localparam anpr_pkg::anpr_state_t RESET_STATE = '{
        adv: `ANPR_RST_ADV,
        adv_lat: `ANPR_RST_ADV,
        lp_base: `ANPR_RST_ZERO,
        np_tx: `ANPR_RST_NP_TX,
        lp_np: `ANPR_RST_ZERO,
        exp_pd_fault: 1'b0,
        exp_page_rx: 1'b0,
        exp_lp_np_able: 1'b0,
        exp_lp_an_able: 1'b0,
        rdata: `ANPR_RST_ZERO,
        rd_hit: 1'b0,
        restart: 1'b0
    };

    anpr_pkg::anpr_state_t state_q;
    anpr_pkg::anpr_state_t state_d;

    // Merges a write into a register, keeping read-only bits as they are.
    function automatic logic [15:0] masked_write(
        input logic [15:0] old_val,
        input logic [15:0] new_val,
        input logic [15:0] mask
    );
        masked_write = (new_val & mask) | (old_val & ~mask);
    endfunction : masked_write

    // Builds the expansion word from the flag bits.
    function automatic logic [15:0] expansion_word(
        input anpr_pkg::anpr_state_t s
    );
        logic [15:0] w;
        w = `ANPR_RST_ZERO;
        w[`ANPR_BIT_EXP_PD_FAULT] = s.exp_pd_fault;
        w[`ANPR_BIT_EXP_LP_NP_ABLE] = s.exp_lp_np_able;
        w[`ANPR_BIT_EXP_LOCAL_NP_ABLE] = 1'b1;
        w[`ANPR_BIT_EXP_PAGE_RX] = s.exp_page_rx;
        w[`ANPR_BIT_EXP_LP_AN_ABLE] = s.exp_lp_an_able;
        expansion_word = w;
    endfunction : expansion_word

    // Tells whether an address belongs to this bank for reads.
    function automatic logic read_hit(
        input logic [4:0] addr
    );
        logic hit;
        hit = 1'b0;
        if (addr == `ANPR_OFF_ADV)
        begin
            hit = 1'b1;
        end
        else if (addr == `ANPR_OFF_LP_BASE)
        begin
            hit = 1'b1;
        end
        else if (addr == `ANPR_OFF_EXPANSION)
        begin
            hit = 1'b1;
        end
        else if (addr == `ANPR_OFF_NP_TX)
        begin
            hit = 1'b1;
        end
        else if (addr == `ANPR_OFF_LP_NP_RX)
        begin
            hit = 1'b1;
        end
        read_hit = hit;
    endfunction : read_hit

    // Selects the word returned for a read; unmapped addresses give zero.
    function automatic logic [15:0] read_word(
        input anpr_pkg::anpr_state_t s,
        input logic [4:0] addr
    );
        logic [15:0] w;
        w = `ANPR_RST_ZERO;
        if (addr == `ANPR_OFF_ADV)
        begin
            w = s.adv;
        end
        else if (addr == `ANPR_OFF_LP_BASE)
        begin
            w = s.lp_base; // [RULE8] [RULE10]
        end
        else if (addr == `ANPR_OFF_EXPANSION)
        begin
            w = expansion_word(s); // [RULE13] [RULE15]
        end
        else if (addr == `ANPR_OFF_NP_TX)
        begin
            w = s.np_tx;
        end
        else if (addr == `ANPR_OFF_LP_NP_RX)
        begin
            w = s.lp_np;
        end
        read_word = w;
    endfunction : read_word

    // Next-state logic for every register of the bank.
    always_comb
    begin
        state_d = state_q;
        state_d.restart = 1'b0;
        state_d.rd_hit = 1'b0;

        // Software writes; read-only fields are protected by the masks.
        if (mgmt_req.wr)
        begin
            if (mgmt_req.addr == `ANPR_OFF_ADV)
            begin
                // Pause, ability, selector and request bits are plain storage; the fault bit also clears on a successful negotiation.
                state_d.adv = masked_write(state_q.adv, mgmt_req.wdata, `ANPR_WMASK_ADV); // [RULE1] [RULE3] [RULE4] [RULE6]
            end
            else if (mgmt_req.addr == `ANPR_OFF_NP_TX)
            begin
                // Toggle and reserved bit 14 stay out of reach of software.
                state_d.np_tx = masked_write(state_q.np_tx, mgmt_req.wdata, `ANPR_WMASK_NP_TX); // [RULE16] [RULE17] [RULE18] [RULE20]
            end
            else if (mgmt_req.addr == `ANPR_OFF_MODE_CTRL)
            begin
                // Restart is a one-cycle registered pulse that no read returns, so it reads as zero.
                state_d.restart = mgmt_req.wdata[`ANPR_BIT_RESTART]; // [RULE23]
            end
        end

        // A successful negotiation drops the transmitted remote fault request.
        if (eng_in.neg_success)
        begin
            state_d.adv[`ANPR_BIT_REMOTE_FAULT] = 1'b0; // [RULE2]
        end

        // The engine works from a copy taken when ability detection begins.
        if (eng_in.ability_detect_enter)
        begin
            state_d.adv_lat = state_q.adv; // [RULE22]
            state_d.np_tx[`ANPR_BIT_TOGGLE] = ~state_q.adv[`ANPR_BIT_ASYM_PAUSE]; // [RULE19]
        end

        // Each exchanged word flips the toggle for the next one.
        if (eng_in.tx_exchanged)
        begin
            state_d.np_tx[`ANPR_BIT_TOGGLE] = ~state_q.np_tx[`ANPR_BIT_TOGGLE]; // [RULE19]
        end

        // Received partner pages land in the base or next-page register.
        if (eng_in.page_rx)
        begin
            if (eng_in.rx_is_base)
            begin
                state_d.lp_base = eng_in.rx_word; // [RULE7] [RULE9]
                state_d.exp_lp_np_able = eng_in.rx_word[`ANPR_BIT_NEXT_PAGE]; // [RULE12]
                state_d.exp_lp_an_able = 1'b1; // [RULE15]
            end
            else
            begin
                state_d.lp_np = eng_in.rx_word; // [RULE21]
            end
        end

        // A read returns the word; an expansion read clears the sticky flags at its completion.
        if (mgmt_req.rd)
        begin
            state_d.rdata = read_word(state_q, mgmt_req.addr);
            state_d.rd_hit = read_hit(mgmt_req.addr);
            if (mgmt_req.addr == `ANPR_OFF_EXPANSION)
            begin
                state_d.exp_pd_fault = 1'b0; // [RULE24]
                state_d.exp_page_rx = 1'b0; // [RULE24]
            end
        end

        // Events are applied last so that they win over a clearing read.
        if (eng_in.pd_fault)
        begin
            state_d.exp_pd_fault = 1'b1; // [RULE11] [RULE24]
        end
        if (eng_in.page_rx)
        begin
            state_d.exp_page_rx = 1'b1; // [RULE14] [RULE24]
        end
    end

    // Registers the bank; reset restores all defaults.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_q <= RESET_STATE; // [RULE5]
        end
        else
        begin
            state_q <= state_d;
        end
    end

    // Outputs straight from the state.
    assign mgmt_rdata = state_q.rdata;
    assign mgmt_rd_hit = state_q.rd_hit;
    assign eng_out.adv_sampled = state_q.adv_lat; // [RULE22]
    assign eng_out.np_tx_word = state_q.np_tx; // [RULE20]
    assign eng_out.lp_ack = state_q.lp_base[`ANPR_BIT_ACK]; // [RULE9]
    assign eng_out.restart = state_q.restart; // [RULE23]

    // The completion level qualifies nothing and is not stored; it is only tied off here.
    logic unused_complete;
    assign unused_complete = an_complete;

endmodule : anpr_page_regs

// [verif/anpr_checker.sv]
// Concurrent checks on the negotiation page register bank ports.
`timescale 1ns/1ps
module anpr_checker (
    input wire logic clk,
    input wire logic rst,
    input wire anpr_pkg::anpr_mgmt_req_t mgmt_req,
    input wire logic [15:0] mgmt_rdata,
    input wire logic mgmt_rd_hit,
    input wire anpr_pkg::anpr_eng_in_t eng_in,
    input wire logic an_complete,
    input wire anpr_pkg::anpr_eng_out_t eng_out
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic exp_rd;
    logic rst_wr;
    // Decodes of an expansion read and of a restart write.
    assign exp_rd = mgmt_req.rd && mgmt_req.addr == 5'h06;
    assign rst_wr = mgmt_req.wr && mgmt_req.addr == 5'h00 && mgmt_req.wdata[9];
    chk_restart_pulse: assert property (rst_wr |=> eng_out.restart) else $error("restart missing");
    chk_restart_only: assert property (!rst_wr |=> !eng_out.restart) else $error("restart stray");
    chk_ctrl_zero: assert property (mgmt_req.rd && mgmt_req.addr == 5'h00 |=> mgmt_rdata == 16'h0000)
        else $error("restart bit read");
    chk_exp_fixed: assert property (exp_rd |=> mgmt_rdata[15:5] == 11'h000 && mgmt_rdata[2])
        else $error("expansion fixed bits");
    chk_fault_sticky: assert property (eng_in.pd_fault ##1 !exp_rd ##1 exp_rd |=> mgmt_rdata[4])
        else $error("fault lost");
    chk_page_sticky: assert property (eng_in.page_rx ##1 !exp_rd ##1 exp_rd |=> mgmt_rdata[1])
        else $error("page flag lost");
    chk_read_clear: assert property (exp_rd && !eng_in.pd_fault && !eng_in.page_rx ##1
        !eng_in.pd_fault && !eng_in.page_rx ##1 exp_rd |=> !mgmt_rdata[4] && !mgmt_rdata[1])
        else $error("flags not cleared");
    chk_partner_ack: assert property (eng_in.page_rx && eng_in.rx_is_base |=>
        eng_out.lp_ack == $past(eng_in.rx_word[14])) else $error("ack wrong");
    chk_toggle_flip: assert property (eng_in.tx_exchanged |=>
        eng_out.np_tx_word[11] != $past(eng_out.np_tx_word[11])) else $error("toggle stuck");
    chk_snapshot_hold: assert property (!eng_in.ability_detect_enter |=> $stable(eng_out.adv_sampled))
        else $error("snapshot moved");
endmodule : anpr_checker

bind anpr_page_regs anpr_checker i_chk (.clk(clk), .rst(rst), .mgmt_req(mgmt_req), .mgmt_rdata(mgmt_rdata),
    .mgmt_rd_hit(mgmt_rd_hit), .eng_in(eng_in), .an_complete(an_complete), .eng_out(eng_out));

// [verif/anpr_mgmt_master.sv]
// Station management master model issuing single-word register accesses.
`timescale 1ns/1ps
module anpr_mgmt_master (
    input wire logic clk,
    output anpr_pkg::anpr_mgmt_req_t mgmt_req,
    input wire logic [15:0] mgmt_rdata,
    input wire logic mgmt_rd_hit
);
    initial mgmt_req = '0;

    // One strobe cycle per access; released lines show inverted values so stale data is never trusted.
    task automatic xfer(input logic rd, input logic wr, input logic [4:0] a, input logic [15:0] d,
        output logic [15:0] q, output logic hit);
        @(negedge clk);
        mgmt_req = '{rd: rd, wr: wr, addr: a, wdata: d};
        @(negedge clk);
        q = mgmt_rdata;
        hit = mgmt_rd_hit;
        mgmt_req = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
    endtask : xfer
endmodule : anpr_mgmt_master

// [verif/testbench.sv]
// Self-checking bench for the negotiation page register bank.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin mismatches++; $display("[ERR] %s exp %h got %h", nm, e, g); end end
module testbench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic an_complete = 1'b0;
    anpr_pkg::anpr_mgmt_req_t mgmt_req;
    anpr_pkg::anpr_eng_in_t eng = '0;
    anpr_pkg::anpr_eng_out_t eng_out;
    logic [15:0] mgmt_rdata;
    logic mgmt_rd_hit;
    logic [15:0] rd_val;
    logic rd_hit;
    logic hit_exp;
    int mismatches = 0;
    int checks = 0;

    // Free-running 25 MHz clock.
    always #20 clk = ~clk;

    anpr_page_regs i_dut (.clk(clk), .rst(rst), .mgmt_req(mgmt_req), .mgmt_rdata(mgmt_rdata),
        .mgmt_rd_hit(mgmt_rd_hit), .eng_in(eng), .an_complete(an_complete), .eng_out(eng_out));
    anpr_mgmt_master i_mst (.clk(clk), .mgmt_req(mgmt_req), .mgmt_rdata(mgmt_rdata), .mgmt_rd_hit(mgmt_rd_hit));

    // Reads a register and compares data and hit flag.
    task automatic rchk(input logic [4:0] a, input logic [15:0] e, input string nm);
        i_mst.xfer(1'b1, 1'b0, a, 16'h0000, rd_val, rd_hit);
        hit_exp = a >= 5'h04 && a <= 5'h08;
        `CHK(nm, e, rd_val);
        `CHK("hit", hit_exp, rd_hit);
    endtask : rchk

    task automatic wreg(input logic [4:0] a, input logic [15:0] d);
        i_mst.xfer(1'b0, 1'b1, a, d, rd_val, rd_hit);
    endtask : wreg

    // Presents one engine event for a single cycle.
    task automatic ev(input anpr_pkg::anpr_eng_in_t e);
        @(negedge clk);
        eng = e;
        @(negedge clk);
        // Released word shows the inverse so that stale page data is never taken as fresh.
        eng = '{rx_word: ~e.rx_word, default: '0};
    endtask : ev

    task automatic t_reset_values;
        rchk(5'h04, 16'h0DE1, "adv");
        rchk(5'h05, 16'h0000, "lp_base");
        rchk(5'h06, 16'h0004, "exp");
        rchk(5'h07, 16'h2001, "np_tx");
        rchk(5'h08, 16'h0000, "lp_np");
    endtask : t_reset_values

    task automatic t_adv;
        wreg(5'h04, 16'hFFFF);
        rchk(5'h04, 16'hBFFF, "adv wr");
        ev('{neg_success: 1'b1, default: '0});
        rchk(5'h04, 16'h9FFF, "adv rf");
        ev('{ability_detect_enter: 1'b1, default: '0});
        `CHK("snap", 16'h9FFF, eng_out.adv_sampled);
        wreg(5'h04, 16'h0DE1);
        `CHK("snap hold", 16'h9FFF, eng_out.adv_sampled);
        ev('{ability_detect_enter: 1'b1, default: '0});
        `CHK("snap new", 16'h0DE1, eng_out.adv_sampled);
    endtask : t_adv

    task automatic t_base_page;
        ev('{page_rx: 1'b1, rx_is_base: 1'b1, rx_word: 16'hEDE1, default: '0});
        an_complete = 1'b1;
        `CHK("lp_ack", 1'b1, eng_out.lp_ack);
        rchk(5'h05, 16'hEDE1, "lp_base pg");
        rchk(5'h06, 16'h000F, "exp pg");
        wreg(5'h06, 16'hFFFF);
        rchk(5'h06, 16'h000D, "exp clr");
    endtask : t_base_page

    task automatic t_fault;
        ev('{pd_fault: 1'b1, default: '0});
        rchk(5'h06, 16'h001D, "exp pd");
        fork
            rchk(5'h06, 16'h000D, "exp race");
            ev('{pd_fault: 1'b1, default: '0});
        join
        rchk(5'h06, 16'h001D, "exp kept");
        rchk(5'h06, 16'h000D, "exp gone");
    endtask : t_fault

    task automatic t_next_page;
        wreg(5'h07, 16'hFFFF);
        rchk(5'h07, 16'hB7FF, "np wr");
        ev('{tx_exchanged: 1'b1, default: '0});
        rchk(5'h07, 16'hBFFF, "np tog");
        `CHK("np word", 16'hBFFF, eng_out.np_tx_word);
        ev('{page_rx: 1'b1, rx_word: 16'h1234, default: '0});
        rchk(5'h08, 16'h1234, "lp_np pg");
        rchk(5'h06, 16'h000F, "exp np");
    endtask : t_next_page

    task automatic t_restart;
        wreg(5'h00, 16'h0200);
        `CHK("restart", 1'b1, eng_out.restart);
        rchk(5'h00, 16'h0000, "ctrl rd");
        `CHK("restart off", 1'b0, eng_out.restart);
        @(negedge clk);
        rst = 1'b1;
        @(negedge clk);
        rst = 1'b0;
        rchk(5'h04, 16'h0DE1, "adv rst");
    endtask : t_restart

    task automatic final_report;
        if (mismatches == 0 && checks > 0)
        begin
            $display("All checks passed");
        end
        else
        begin
            $display("Checks failed");
        end
        $finish;
    endtask : final_report

    // Main sequence after a 12-cycle reset.
    initial
    begin
        repeat (12) @(negedge clk);
        rst = 1'b0;
        t_reset_values();
        t_adv();
        t_base_page();
        t_fault();
        t_next_page();
        t_restart();
        final_report();
    end

    // Watchdog well beyond the expected fewer than a hundred cycles.
    initial
    begin
        #80000;
        mismatches++;
        final_report();
    end
endmodule : testbench
